/* logic/irc_codec.sv */
// Purpose: Infrared UART codec top: pulse encoder, decoder, baud control.
// Assumes: 20 MHz mclk; pins are asynchronous and synchronised here.
// Notes: One shared tick divider serves both directions (half duplex).
//
// Summary of operation
// - Held in reset while reset is low, then timer, then run.
// - Sixteen sub-bit ticks per bit time time start and data bits.
// - Stop bit tick-timed on transmit, not on receive.
// - Half duplex: transmit or receive, never both at once.
// - Rate pins 000..100 select divide by 768, 384, 192, 128, 64.
// - Rate pins 111 select software rate, defaulting to divide by 768.
// - Mode low with rate pins 111: echo UART bytes within one bit, no infrared coding.
// - Mode high: data mode, encoding and decoding operate.
// - Codes 87, 8b, 85, 83, 81 select 768, 384, 192, 128, 64.
// - Change command 11 adopts last valid code after echo stop bit.
// - Encoded start follows UART start edge; bits sixteen ticks apart.
// - Decoded start follows infrared edge; bits sixteen ticks apart.
// - Zero bit: output low seven ticks, high three, low six.
// - One bit: infrared output low for all sixteen ticks.
// - Input low three ticks is zero; high all sixteen is one.
// - Each decoded bit except the last data bit holds on UART output for sixteen ticks.
// - Enable low disables operation into a low power state.
// - After enable rises, no traffic for 1000 oscillator periods.
`timescale 1ns/1ps
module irc_codec
  import irc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Controller UART side
  input wire logic uart_rx_in,
  output logic uart_tx_out,
  // Optical transceiver side
  input wire logic optical_rx_in,
  output logic optical_tx_out,
  // Configuration pins
  input wire logic [2:0] rate_select_pins,
  input wire logic mode_data,
  input wire logic enable,
  // Status
  output logic running
);
  typedef enum logic [2:0] {
    DIR_IDLE = 3'h1,
    DIR_TX = 3'h2,
    DIR_RX = 3'h4
  } irc_dir_type;

  function automatic logic [5:0] sel_to_div(input logic [2:0] sel);
    case (sel)
      SEL_384: sel_to_div = TICK_384;
      SEL_192: sel_to_div = TICK_192;
      SEL_128: sel_to_div = TICK_128;
      SEL_64: sel_to_div = TICK_64;
      default: sel_to_div = TICK_768;
    endcase
  endfunction

  function automatic logic [3:0] code_to_sel(input logic [7:0] code);
    case (code)
      CMD_768: code_to_sel = {1'b0, SEL_768};
      CMD_384: code_to_sel = {1'b0, SEL_384};
      CMD_192: code_to_sel = {1'b0, SEL_192};
      CMD_128: code_to_sel = {1'b0, SEL_128};
      CMD_64: code_to_sel = {1'b0, SEL_64};
      default: code_to_sel = 4'h8;
    endcase
  endfunction

  // Synchronised pins.
  logic [6:0] pins_s;
  logic urx_s, orx_s, mode_s, en_s;
  logic [2:0] rate_s;
  // Reset values are the idle pins with the part enabled. A low enable here
  // would send the sequencer to sleep for the first edges after reset.
  irc_sync #(.WIDTH(7), .INIT(7'h7b)) u_sync (
    .mclk(mclk),
    .rstn(rstn),
    .d({uart_rx_in, optical_rx_in, mode_data, enable, rate_select_pins}),
    .q(pins_s)
  );
  assign {urx_s, orx_s, mode_s, en_s, rate_s} = pins_s;

  // Power and reset sequencing.
  irc_state_type st_reg, st_next;
  logic [9:0] dly_reg, dly_next;
  logic run;

  always_comb begin
    st_next = st_reg;
    dly_next = dly_reg;
    case (st_reg)
      ST_RESET: begin
        st_next = ST_WAIT;
        dly_next = RESET_DELAY_CYC - 10'h1;
      end
      ST_WAIT: begin
        if (!en_s) begin
          st_next = ST_SLEEP;
        end else if (dly_reg == 10'h0) begin
          st_next = ST_RUN;
        end else begin
          dly_next = dly_reg - 10'h1;
        end
      end
      ST_RUN: begin
        if (!en_s) begin
          st_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (en_s) begin
          st_next = ST_WAIT;
          dly_next = WAKE_DELAY_CYC - 10'h1;
        end
      end
      default: st_next = ST_RESET;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= ST_RESET;
      dly_reg <= 10'h0;
    end else begin
      st_reg <= st_next;
      dly_reg <= dly_next;
    end
  end

  assign run = (st_reg == ST_RUN);
  assign running = run;

  // Tick generation and framing state.
  irc_dir_type dir_reg, dir_next;
  logic [3:0] sub_reg, sub_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] shf_reg, shf_next;
  logic val_reg, val_next;
  logic itx_reg, itx_next;
  logic utx_reg, utx_next;
  logic rxlow_reg, rxlow_next;
  logic urx_d_reg, orx_d_reg;
  logic [2:0] soft_reg, soft_next;
  logic [3:0] pend_reg, pend_next;
  logic chg_reg, chg_next;
  logic tick, restart;
  logic [2:0] cur_sel;
  logic [5:0] period;
  logic cmd_mode;
  logic [3:0] code_sel;
  logic u_fall, o_fall;
  irc_ctrl_type ctrl;

  assign cur_sel = (rate_s == SEL_SOFT) ? soft_reg : rate_s;
  assign period = sel_to_div(cur_sel);
  assign cmd_mode = !mode_s && (rate_s == SEL_SOFT);
  assign code_sel = code_to_sel(shf_reg);
  assign ctrl = '{mode_cmd: cmd_mode, run: run, tick_div: period};
  assign u_fall = urx_d_reg && !urx_s;
  assign o_fall = orx_d_reg && !orx_s;
  // Only one direction starts at a time; transmit wins a tie.
  assign restart = ctrl.run && (dir_reg == DIR_IDLE) &&
                   (u_fall || (o_fall && !ctrl.mode_cmd));

  irc_tick_gen u_tick (
    .mclk(mclk),
    .rstn(rstn),
    .restart(restart),
    .period(ctrl.tick_div),
    .tick(tick)
  );

  always_comb begin
    dir_next = dir_reg;
    sub_next = sub_reg;
    bit_next = bit_reg;
    shf_next = shf_reg;
    val_next = val_reg;
    itx_next = 1'b0;
    utx_next = utx_reg;
    rxlow_next = rxlow_reg;
    soft_next = soft_reg;
    pend_next = pend_reg;
    chg_next = chg_reg;
    case (dir_reg)
      DIR_IDLE: begin
        utx_next = 1'b1;
        sub_next = 4'h0;
        bit_next = 4'h0;
        if (restart && u_fall) begin
          dir_next = DIR_TX;
          val_next = 1'b0;
        end else if (restart) begin
          dir_next = DIR_RX;
          rxlow_next = 1'b0;
        end
      end
      DIR_TX: begin
        // Encoder or, in command mode, echo of the sampled level.
        if (ctrl.mode_cmd) begin
          utx_next = val_reg;
        end else if (!val_reg && sub_reg >= ZERO_PULSE_START &&
                     sub_reg < ZERO_PULSE_END) begin
          itx_next = 1'b1;
        end
        if (tick) begin
          sub_next = sub_reg + 4'h1;
          if (sub_reg == 4'h7 && bit_reg != 4'h0 &&
              bit_reg != TX_BITS_LAST) begin
            shf_next = {urx_s, shf_reg[7:1]};
          end
          if (sub_reg == TICK_LAST) begin
            bit_next = bit_reg + 4'h1;
            val_next = urx_s;
            if (bit_reg == TX_BITS_LAST) begin
              dir_next = DIR_IDLE;
              utx_next = 1'b1;
              val_next = 1'b0;
              if (ctrl.mode_cmd) begin
                if (chg_reg) begin
                  soft_next = pend_reg[2:0];
                  chg_next = 1'b0;
                end
                if (shf_reg == CMD_CHANGE) begin
                  if (!pend_reg[3]) begin
                    chg_next = 1'b1;
                  end
                end else if (!code_sel[3]) begin
                  pend_next = code_sel;
                end
              end
            end
          end
        end
        if (chg_next && dir_next == DIR_IDLE) begin
          soft_next = pend_next[2:0];
          chg_next = 1'b0;
        end
      end
      DIR_RX: begin
        if (tick) begin
          sub_next = sub_reg + 4'h1;
          if (sub_reg <= RX_DECIDE_TICK && !orx_s) begin
            rxlow_next = 1'b1;
          end
          if (sub_reg == RX_DECIDE_TICK) begin
            utx_next = !(rxlow_reg || !orx_s);
          end
          if (sub_reg == TICK_LAST) begin
            bit_next = bit_reg + 4'h1;
            rxlow_next = 1'b0;
            if (bit_reg == RX_BITS_LAST) begin
              // Stop bit is not tick-timed: release the line now.
              dir_next = DIR_IDLE;
              utx_next = 1'b1;
            end
          end
        end
      end
      default: dir_next = DIR_IDLE;
    endcase
    if (!ctrl.run) begin
      dir_next = DIR_IDLE;
      utx_next = 1'b1;
      itx_next = 1'b0;
    end
    if (rate_s != SEL_SOFT) begin
      soft_next = SEL_768;
      chg_next = 1'b0;
      pend_next = {1'b0, SEL_768};
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      dir_reg <= DIR_IDLE;
      sub_reg <= 4'h0;
      bit_reg <= 4'h0;
      shf_reg <= 8'h00;
      val_reg <= 1'b0;
      itx_reg <= 1'b0;
      utx_reg <= 1'b1;
      rxlow_reg <= 1'b0;
      soft_reg <= SEL_768;
      pend_reg <= {1'b0, SEL_768};
      chg_reg <= 1'b0;
      urx_d_reg <= 1'b1;
      orx_d_reg <= 1'b1;
    end else begin
      dir_reg <= dir_next;
      sub_reg <= sub_next;
      bit_reg <= bit_next;
      shf_reg <= shf_next;
      val_reg <= val_next;
      itx_reg <= itx_next;
      utx_reg <= utx_next;
      rxlow_reg <= rxlow_next;
      soft_reg <= soft_next;
      pend_reg <= pend_next;
      chg_reg <= chg_next;
      urx_d_reg <= urx_s;
      orx_d_reg <= orx_s;
    end
  end

  assign optical_tx_out = itx_reg;
  assign uart_tx_out = utx_reg;
endmodule // irc_codec

/* logic/irc_sync.sv */
// Purpose: Two-stage synchroniser for a bundle of pin inputs.
// Assumes: Each bit is an independent level.
// Notes: Only the second stage may be read by logic.
`timescale 1ns/1ps
module irc_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] s1_reg;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s1_reg <= INIT;
      q <= INIT;
    end else begin
      s1_reg <= d;
      q <= s1_reg;
    end
  end
endmodule // irc_sync

/* logic/irc_tick_gen.sv */
// Purpose: Sub-bit tick divider, one enable pulse per tick period.
// Assumes: Period is at least two clock cycles.
// Notes: Restart realigns the phase to a detected start edge.
`timescale 1ns/1ps
module irc_tick_gen
  import irc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Control
  input wire logic restart,
  input wire logic [5:0] period,
  // Tick
  output logic tick
);
  logic [5:0] cnt_reg, cnt_next;

  always_comb begin
    cnt_next = cnt_reg + 6'h1;
    if (restart || cnt_next >= period) begin
      cnt_next = 6'h0;
    end
  end

  assign tick = (cnt_reg == period - 6'h1) && !restart;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 6'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule // irc_tick_gen

/* pkg/irc_pkg.sv */
// Purpose: Shared constants and types for the infrared UART codec.
// Assumes: 20 MHz master clock, sixteen sub-bit ticks per bit.
// Notes: Divider values are in master clock cycles per sub-bit tick.
package irc_pkg;
  localparam int CLK_HZ = 20000000;
  localparam int TICKS_PER_BIT = 16;
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] ZERO_PULSE_START = 4'h7;
  localparam logic [3:0] ZERO_PULSE_END = 4'ha;
  localparam logic [3:0] RX_DECIDE_TICK = 4'h2;
  localparam logic [3:0] RX_BITS_LAST = 4'h8;
  localparam logic [3:0] TX_BITS_LAST = 4'h9;
  // Oscillator divide ratios per bit, turned into cycles per tick.
  localparam int DIV_768 = 768;
  localparam int DIV_384 = 384;
  localparam int DIV_192 = 192;
  localparam int DIV_128 = 128;
  localparam int DIV_64 = 64;
  localparam logic [5:0] TICK_768 = 6'(DIV_768 / TICKS_PER_BIT);
  localparam logic [5:0] TICK_384 = 6'(DIV_384 / TICKS_PER_BIT);
  localparam logic [5:0] TICK_192 = 6'(DIV_192 / TICKS_PER_BIT);
  localparam logic [5:0] TICK_128 = 6'(DIV_128 / TICKS_PER_BIT);
  localparam logic [5:0] TICK_64 = 6'(DIV_64 / TICKS_PER_BIT);
  localparam logic [2:0] SEL_768 = 3'h0;
  localparam logic [2:0] SEL_384 = 3'h1;
  localparam logic [2:0] SEL_192 = 3'h2;
  localparam logic [2:0] SEL_128 = 3'h3;
  localparam logic [2:0] SEL_64 = 3'h4;
  localparam logic [2:0] SEL_SOFT = 3'h7;
  localparam logic [7:0] CMD_768 = 8'h87;
  localparam logic [7:0] CMD_384 = 8'h8b;
  localparam logic [7:0] CMD_192 = 8'h85;
  localparam logic [7:0] CMD_128 = 8'h83;
  localparam logic [7:0] CMD_64 = 8'h81;
  localparam logic [7:0] CMD_CHANGE = 8'h11;
  // Reset delay timer and wake delay, in oscillator periods.
  localparam int RESET_DELAY_TOSC = 1000;
  localparam int WAKE_DELAY_TOSC = 1000;
  localparam logic [9:0] RESET_DELAY_CYC = 10'(RESET_DELAY_TOSC);
  localparam logic [9:0] WAKE_DELAY_CYC = 10'(WAKE_DELAY_TOSC);

  typedef enum logic [3:0] {
    ST_RESET = 4'h1,
    ST_WAIT = 4'h2,
    ST_RUN = 4'h4,
    ST_SLEEP = 4'h8
  } irc_state_type;

  typedef struct packed {
    logic mode_cmd;
    logic run;
    logic [5:0] tick_div;
  } irc_ctrl_type;
endpackage

/* test/irc_codec_asserts.sv */
// Purpose: Port checks for the infrared UART codec.
// Assumes: One clock domain, reset active low.
// Notes: A quiet counter stands in for the hidden frame state.
`timescale 1ns/1ps
module irc_codec_chk (
  // Design ports
  input wire logic mclk,
  input wire logic rstn,
  input wire logic uart_rx_in,
  input wire logic uart_tx_out,
  input wire logic optical_rx_in,
  input wire logic optical_tx_out,
  input wire logic [2:0] rate_select_pins,
  input wire logic mode_data,
  input wire logic enable,
  input wire logic running
);
  logic [10:0] wait_reg, wait_next, quiet_reg, quiet_next;
  logic [7:0] hi_reg, hi_next;
  logic fast;
  always_comb begin
    wait_next = enable ? wait_reg + 11'(wait_reg != 11'h7ff) : 11'h0;
    quiet_next = (uart_rx_in && optical_rx_in) ?
      quiet_reg + 11'(quiet_reg != 11'h7ff) : 11'h0;
    hi_next = optical_tx_out ? hi_reg + 8'h1 : 8'h0;
    fast = mode_data && running && rate_select_pins == 3'h4 &&
      quiet_reg >= 11'h5dc;
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wait_reg <= 11'h0;
      quiet_reg <= 11'h0;
      hi_reg <= 8'h0;
    end else begin
      wait_reg <= wait_next;
      quiet_reg <= quiet_next;
      hi_reg <= hi_next;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Windows allow for the pin synchronisers and tick realignment.
  sequence ir_start_pulse;
    !optical_tx_out [*8] ##[22:40] $rose(optical_tx_out);
  endsequence
  sequence uart_start_bit;
    uart_tx_out [*6] ##[3:12] !uart_tx_out;
  endsequence
  run_delay_a: assert property (
    $rose(running) |-> wait_reg >= 11'h3e8)
    else $error("running rose early");
  sleep_a: assert property (
    !enable [*5] |-> !running)
    else $error("running while disabled");
  idle_out_a: assert property (
    !running && !$past(running) |-> uart_tx_out && !optical_tx_out)
    else $error("outputs not idle when stopped");
  pulse_width_a: assert property (
    $fell(optical_tx_out) && running |->
      hi_reg inside {8'h0c, 8'h18, 8'h24, 8'h48, 8'h90})
    else $error("optical pulse width wrong");
  cmd_no_ir_a: assert property (
    (rate_select_pins == 3'h7 && !mode_data) [*4] |-> !optical_tx_out)
    else $error("optical output in command mode");
  quiet_line_a: assert property (
    quiet_reg >= 11'h5dc |-> uart_tx_out && !optical_tx_out)
    else $error("output active on quiet lines");
  tx_start_a: assert property (
    $fell(uart_rx_in) && fast |-> ir_start_pulse)
    else $error("start pulse misplaced");
  rx_start_a: assert property (
    $fell(optical_rx_in) && fast |-> uart_start_bit)
    else $error("decoded start misplaced");
endmodule // irc_codec_chk

bind irc_codec irc_codec_chk irc_codec_chk_i (.mclk, .rstn, .uart_rx_in,
  .uart_tx_out, .optical_rx_in, .optical_tx_out, .rate_select_pins,
  .mode_data, .enable, .running);

/* test/irc_far_model.sv */
// Purpose: Far side model: controller UART and optical transceiver.
// Assumes: Both lines idle high; one frame at a time.
// Notes: A busy flag keeps the link half duplex.
`timescale 1ns/1ps
module irc_far_model (
  // Clock and status
  input wire logic mclk,
  input wire logic running,
  // Lines into the codec
  output logic uart_rx_in,
  output logic optical_rx_in
);
  logic busy = 1'b0;
  initial begin
    uart_rx_in = 1'b1;
    optical_rx_in = 1'b1;
  end
  task automatic hold_off();
    @(posedge mclk);
    while (!running || busy) @(posedge mclk);
    busy = 1'b1;
  endtask
  task automatic send_uart(input logic [7:0] d, input int bc);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    hold_off();
    for (int i = 0; i < 10; i++) begin
      uart_rx_in <= f[i];
      repeat (bc) @(posedge mclk);
    end
    busy = 1'b0;
  endtask
  // A zero is a short low pulse; the model drives the line high for the rest.
  task automatic send_ir(input logic [7:0] d, input int p);
    logic [8:0] f;
    f = {d, 1'b0};
    hold_off();
    for (int i = 0; i < 9; i++) begin
      optical_rx_in <= f[i];
      repeat (3 * p) @(posedge mclk);
      optical_rx_in <= 1'b1;
      repeat (13 * p) @(posedge mclk);
    end
    busy = 1'b0;
  endtask
endmodule // irc_far_model

/* test/testbench.sv */
// Purpose: Self-checking bench for the infrared UART codec.
// Assumes: 20 MHz clock; far side model drives both input lines.
// Notes: Pulse counts and spacings are measured in clock cycles.
`timescale 1ns/1ps
module testbench
  import irc_pkg::*;
();
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic mode_data = 1'b1;
  logic enable = 1'b1;
  logic [2:0] rate_select_pins = 3'h4;
  logic uart_rx_in, optical_rx_in, uart_tx_out, optical_tx_out, running;
  int err_total = 0, checks = 0, cyc_cnt = 0, rises = 0, t0, t1, prev;
  logic [7:0] seed = 8'h0f;
  logic [7:0] got;
  logic [5:0] p_tab [5] = '{TICK_768, TICK_384, TICK_192, TICK_128,
    TICK_64};
  logic [7:0] code_tab [5] = '{CMD_64, CMD_128, CMD_192, CMD_384, CMD_768};
  initial begin
    forever #25 mclk = ~mclk;
  end
  irc_codec irc_codec_i (.mclk, .rstn, .uart_rx_in, .uart_tx_out,
    .optical_rx_in, .optical_tx_out, .rate_select_pins, .mode_data,
    .enable, .running);
  irc_far_model irc_far_model_i (.mclk, .running, .uart_rx_in,
    .optical_rx_in);
  always @(posedge optical_tx_out) begin
    if (rises == 0) t0 = cyc_cnt;
    if (rises == 1) t1 = cyc_cnt;
    rises++;
  end
  always @(posedge mclk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 99000) begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (err_total == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Start bit plus every zero data bit gives one pulse.
  function automatic logic [15:0] zero_bits(input logic [7:0] d);
    return 16'(9 - $countones(d));
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic wait_run();
    int n;
    n = 0;
    while (running !== 1'b1 && n < 1200) begin
      @(posedge mclk);
      n++;
    end
    chk(16'h1, 16'(n >= 1000 && n <= 1010));
  endtask
  // Samples mid-bit; waits at most four bit times for the start bit.
  task automatic get_uart(input int bc, output logic [7:0] d);
    for (int k = 0; k < 4 * bc && uart_tx_out; k++) @(posedge mclk);
    cyc(bc / 2);
    for (int i = 0; i < 8; i++) begin
      cyc(bc);
      d[i] = uart_tx_out;
    end
  endtask
  task automatic tx_frame(input logic [7:0] d, input int p);
    rises = 0;
    irc_far_model_i.send_uart(d, 16 * p);
    // Only the fastest rate needs the long gap that arms the quiet checks.
    cyc(p == TICK_64 ? 1600 : 64);
    chk(zero_bits(d), 16'(rises));
    if (d == 8'h00) chk(16'(16 * p), 16'(t1 - t0));
  endtask
  task automatic rx_frame(input logic [7:0] d, input int p);
    fork
      irc_far_model_i.send_ir(d, p);
      get_uart(16 * p, got);
    join
    chk({8'h0, d}, {8'h0, got});
    cyc(1600);
  endtask
  task automatic cmd_byte(input logic [7:0] d, input int p);
    rises = 0;
    fork
      irc_far_model_i.send_uart(d, 16 * p);
      get_uart(16 * p, got);
    join
    chk({8'h0, d}, {8'h0, got});
    chk(16'h0, 16'(rises));
  endtask
  initial begin
    cyc(2);
    chk(16'h4, {13'h0, uart_tx_out, optical_tx_out, running});
    cyc(2);
    rstn <= 1'b1;
    wait_run();
    cyc(1600);
    tx_frame(8'h00, 4);
    tx_frame(8'hff, 4);
    rx_frame(8'h00, 4);
    rx_frame(8'hff, 4);
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      tx_frame(seed, 4);
      seed = lfsr(seed);
      rx_frame(seed, 4);
    end
    for (int s = 0; s < 5; s++) begin
      rate_select_pins <= 3'(s);
      cyc(10);
      tx_frame(8'h00, p_tab[s]);
    end
    rate_select_pins <= SEL_SOFT;
    mode_data <= 1'b0;
    cyc(10);
    prev = TICK_768;
    for (int i = 0; i < 5; i++) begin
      cmd_byte(code_tab[i], prev);
      cmd_byte(CMD_CHANGE, prev);
      cyc(32 * prev);
      mode_data <= 1'b1;
      cyc(10);
      prev = p_tab[4 - i];
      tx_frame(8'h00, prev);
      mode_data <= 1'b0;
      cyc(10);
    end
    enable <= 1'b0;
    cyc(10);
    chk(16'h0, 16'(running));
    enable <= 1'b1;
    wait_run();
    report_and_stop();
  end
endmodule // testbench
